// ---- logic/gper_router.sv ----
// Contract
// - Control bit 0 picks event output polarity
// - Redirected port's hot-plug messages are suppressed
// - Redirected port's hot-plug events drive shared pin
// - Pin carries event only in alternate function
// - Status bit reads one while redirected port signals
// - Status bit never set while redirect disabled
`timescale 1ns/1ps
`default_nettype none

module gper_router (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [11:0] s_axil_awaddr,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  output logic [1:0] s_axil_bresp,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  input wire logic [11:0] s_axil_araddr,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  input wire logic [2:0] hp_event_pending,
  input wire logic [2:0] hp_intx_req,
  input wire logic [2:0] hp_msi_req,
  input wire logic [2:0] hp_pme_req,
  output logic [2:0] hp_intx_out,
  output logic [2:0] hp_msi_out,
  output logic [2:0] hp_pme_out,
  input wire logic gpio7_i,
  output logic gpio7_o,
  output logic gpio7_oe,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [3:0] ctrl_q, ctrl_d;
  logic [2:0] gpio_cfg_q, gpio_cfg_d;
  logic [2:0] flag_q, flag_d;
  logic [2:0] int_sts_q, int_sts_d;
  logic [2:0] int_mask_q, int_mask_d;
  logic wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic gpio7_in_sync;
  logic wr_hit;
  logic rd_hit;

  // ----------------------------------------------------------------
  // Bus slave and pin synchroniser
  // ----------------------------------------------------------------
  gper_axil_slave u_bus (
    .clock(clock),
    .rst_n(rst_n),
    .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready),
    .s_axil_awaddr(s_axil_awaddr),
    .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready),
    .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb),
    .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready),
    .s_axil_bresp(s_axil_bresp),
    .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready),
    .s_axil_araddr(s_axil_araddr),
    .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready),
    .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_hit(wr_hit),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  gper_sync #(
    .WIDTH(1)
  ) u_gpio_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(gpio7_i),
    .sync_out(gpio7_in_sync)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire wsel_ctrl = wr_addr == gper_pkg::OFF_CTRL;
  wire wsel_status = wr_addr == gper_pkg::OFF_STATUS;
  wire wsel_gpio = wr_addr == gper_pkg::OFF_GPIO_CFG;
  wire wsel_int_sts = wr_addr == gper_pkg::OFF_INT_STATUS;
  wire wsel_int_mask = wr_addr == gper_pkg::OFF_INT_MASK;
  // Status is read-only; a write to it is accepted and dropped
  assign wr_hit = wsel_ctrl | wsel_status | wsel_gpio | wsel_int_sts | wsel_int_mask;
  wire wr_lane0 = wr_en & wr_strb[0];
  wire wr_ctrl = wr_lane0 & wsel_ctrl;
  wire wr_gpio = wr_lane0 & wsel_gpio;
  wire wr_int_clr = wr_lane0 & wsel_int_sts;
  wire wr_int_mask = wr_lane0 & wsel_int_mask;

  wire rsel_ctrl = rd_addr == gper_pkg::OFF_CTRL;
  wire rsel_status = rd_addr == gper_pkg::OFF_STATUS;
  wire rsel_gpio = rd_addr == gper_pkg::OFF_GPIO_CFG;
  wire rsel_int_sts = rd_addr == gper_pkg::OFF_INT_STATUS;
  wire rsel_int_mask = rd_addr == gper_pkg::OFF_INT_MASK;
  assign rd_hit = rsel_ctrl | rsel_status | rsel_gpio | rsel_int_sts | rsel_int_mask;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [31:0] rd_ctrl_w = {28'h0000000, ctrl_q};
  wire [31:0] rd_status_w = {28'h0000000, flag_q, 1'b0};
  wire [31:0] rd_gpio_w = {28'h0000000, gpio7_in_sync, gpio_cfg_q};
  wire [31:0] rd_int_sts_w = {28'h0000000, int_sts_q, 1'b0};
  wire [31:0] rd_int_mask_w = {28'h0000000, int_mask_q, 1'b0};
  assign rd_data = ({32{rsel_ctrl}} & rd_ctrl_w)
                 | ({32{rsel_status}} & rd_status_w)
                 | ({32{rsel_gpio}} & rd_gpio_w)
                 | ({32{rsel_int_sts}} & rd_int_sts_w)
                 | ({32{rsel_int_mask}} & rd_int_mask_w);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  assign ctrl_d = wr_ctrl ? wr_data[3:0] : ctrl_q;
  assign gpio_cfg_d = wr_gpio ? wr_data[2:0] : gpio_cfg_q;
  assign int_mask_d = wr_int_mask ? wr_data[3:1] : int_mask_q;

  wire [2:0] en_d = ctrl_d[gper_pkg::CTRL_EN_LSB +: gper_pkg::NUM_PORTS];
  wire pol_d = ctrl_d[gper_pkg::CTRL_POL_BIT];
  wire alt_d = gpio_cfg_d[gper_pkg::GPIO_ALT_BIT];
  // Gated by next enable
  // Using the next enable keeps the flag and its enable changing on the same edge
  assign flag_d = en_d & hp_event_pending;
  wire any_flag_d = |flag_d;
  wire event_level_d = any_flag_d ? pol_d : ~pol_d;
  wire pin_d = alt_d ? event_level_d : gpio_cfg_d[gper_pkg::GPIO_VAL_BIT];
  wire pin_oe_d = alt_d | gpio_cfg_d[gper_pkg::GPIO_OE_BIT];

  // Rising flag edges are the interrupt events; set beats a same-cycle clear
  wire [2:0] flag_rise = flag_d & ~flag_q;
  wire [2:0] int_clr = wr_int_clr ? wr_data[3:1] : 3'h0;
  assign int_sts_d = (int_sts_q & ~int_clr) | flag_rise;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= gper_pkg::CTRL_RST;
      gpio_cfg_q <= gper_pkg::GPIO_CFG_RST;
      int_mask_q <= gper_pkg::PORT_RST;
      int_sts_q <= gper_pkg::PORT_RST;
    end else begin
      ctrl_q <= ctrl_d;
      gpio_cfg_q <= gpio_cfg_d;
      int_mask_q <= int_mask_d;
      int_sts_q <= int_sts_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= gper_pkg::PORT_RST;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Pin reset leaves it undriven; its level is then don't-care
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gpio7_o <= 1'b0;
      gpio7_oe <= 1'b0;
      irq <= 1'b0;
    end else begin
      gpio7_o <= pin_d;
      gpio7_oe <= pin_oe_d;
      irq <= |(int_sts_d & int_mask_d);
    end
  end

  // ----------------------------------------------------------------
  // Message suppression
  // ----------------------------------------------------------------
  for (genvar p = 0; p < gper_pkg::NUM_PORTS; p++) begin : g_port
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        hp_intx_out[p] <= 1'b0;
        hp_msi_out[p] <= 1'b0;
        hp_pme_out[p] <= 1'b0;
      end else begin
        hp_intx_out[p] <= hp_intx_req[p] & ~en_d[p];
        hp_msi_out[p] <= hp_msi_req[p] & ~en_d[p];
        hp_pme_out[p] <= hp_pme_req[p] & ~en_d[p];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  wire [2:0] en_q = ctrl_q[gper_pkg::CTRL_EN_LSB +: gper_pkg::NUM_PORTS];
  wire pol_q = ctrl_q[gper_pkg::CTRL_POL_BIT];
  wire alt_q = gpio_cfg_q[gper_pkg::GPIO_ALT_BIT];

  a_pol_level: assert property (@(posedge clock) disable iff (!rst_n)
    (alt_q && flag_q == 3'h0) |-> (gpio7_o == ~pol_q))
    else $error("Idle event pin level does not match polarity");

  a_msg_suppress: assert property (@(posedge clock) disable iff (!rst_n)
    ((hp_intx_out | hp_msi_out | hp_pme_out) & en_q) == 3'h0)
    else $error("Message leaked from a redirected port");

  a_msg_pass: assert property (@(posedge clock) disable iff (!rst_n)
    (hp_msi_req[0] && !en_d[0]) |=> hp_msi_out[0])
    else $error("Port 1 message lost while not redirected");

  a_event_raise: assert property (@(posedge clock) disable iff (!rst_n)
    (alt_d && ((en_d & hp_event_pending) != 3'h0)) |=> (gpio7_oe && gpio7_o == pol_q))
    else $error("Redirected event did not assert the pin");

  a_alt_only: assert property (@(posedge clock) disable iff (!rst_n)
    !alt_q |-> (gpio7_o == gpio_cfg_q[gper_pkg::GPIO_VAL_BIT]
                && gpio7_oe == gpio_cfg_q[gper_pkg::GPIO_OE_BIT]))
    else $error("Event drove the pin outside its alternate function");

  a_status_track: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(flag_q[1]) |-> $past(hp_event_pending[1])
      ##1 (flag_q[1] || !$past(hp_event_pending[1]) || !$past(en_d[1])))
    else $error("Port 2 status does not follow its event");

  a_status_gated: assert property (@(posedge clock) disable iff (!rst_n)
    (flag_q & ~en_q) == 3'h0)
    else $error("Status set while redirect disabled");

  a_out_tracks: assert property (@(posedge clock) disable iff (!rst_n)
    (alt_q && $fell(|flag_q)) |-> (gpio7_o == ~pol_q) [*2] or (gpio7_o == ~pol_q ##1 (|flag_q || !alt_q)))
    else $error("Event pin did not release with its status");

  a_irq_sticky: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(flag_q[2]) |-> int_sts_q[2] ##1 (int_sts_q[2] || $past(wr_int_clr)))
    else $error("Port 3 interrupt status lost");

  // ----------------------------------------------------------------
  // Interrupt, pass-through and pin checks, and covers
  // ----------------------------------------------------------------
  a_irq_level: assert property (@(posedge clock) disable iff (!rst_n)
    irq == |(int_sts_q & int_mask_q))
    else $error("Interrupt output does not match masked status");

  // Set beats a clear written in the same cycle
  a_int_set_wins: assert property (@(posedge clock) disable iff (!rst_n)
    (flag_d[0] && !flag_q[0]) |=> int_sts_q[0])
    else $error("Port 1 interrupt event lost to a clear");

  a_int_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_int_clr && wr_data[1] && !flag_rise[0]) |=> !int_sts_q[0])
    else $error("Port 1 interrupt status survived its clear");

  a_intx_pass: assert property (@(posedge clock) disable iff (!rst_n)
    (hp_intx_req[2] && !en_d[2]) |=> hp_intx_out[2])
    else $error("Port 3 legacy interrupt lost while not redirected");

  a_pme_pass: assert property (@(posedge clock) disable iff (!rst_n)
    (hp_pme_req[1] && !en_d[1]) |=> hp_pme_out[1])
    else $error("Port 2 power event lost while not redirected");

  a_pin_oe_alt: assert property (@(posedge clock) disable iff (!rst_n)
    alt_q |-> gpio7_oe)
    else $error("Event pin not driven in its alternate function");

  c_redirect_event: cover property (@(posedge clock) disable iff (!rst_n)
    alt_q && pol_q && (flag_q != 3'h0) ##[1:20] (flag_q == 3'h0));

  c_two_ports: cover property (@(posedge clock) disable iff (!rst_n)
    flag_q[0] && flag_q[2]);

  c_irq_clear: cover property (@(posedge clock) disable iff (!rst_n)
    irq ##[1:20] !irq);

  c_active_low: cover property (@(posedge clock) disable iff (!rst_n)
    alt_q && !pol_q && (flag_q != 3'h0));

endmodule : gper_router

`default_nettype wire

// ---- logic/gper_pkg.sv ----
`default_nettype none

package gper_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_CTRL = 12'h450;
  localparam logic [11:0] OFF_STATUS = 12'h454;
  localparam logic [11:0] OFF_GPIO_CFG = 12'h458;
  localparam logic [11:0] OFF_INT_STATUS = 12'h45c;
  localparam logic [11:0] OFF_INT_MASK = 12'h460;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 3;
  localparam int CTRL_POL_BIT = 0;
  localparam int CTRL_EN_LSB = 1;
  localparam int GPIO_ALT_BIT = 0;
  localparam int GPIO_VAL_BIT = 1;
  localparam int GPIO_OE_BIT = 2;
  localparam int GPIO_IN_BIT = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [2:0] GPIO_CFG_RST = 3'h0;
  localparam logic [2:0] PORT_RST = 3'h0;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : gper_pkg

`default_nettype wire

// ---- logic/gper_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module gper_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser per bit
  // ----------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_q;
    logic sync_q;
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end else begin
        meta_q <= async_in[i];
        sync_q <= meta_q;
      end
    end
    assign sync_out[i] = sync_q;
  end

endmodule : gper_sync

`default_nettype wire

// ---- logic/gper_axil_slave.sv ----
`timescale 1ns/1ps
`default_nettype none

module gper_axil_slave (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [11:0] s_axil_awaddr,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  output logic [1:0] s_axil_bresp,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  input wire logic [11:0] s_axil_araddr,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic wr_en,
  output logic [11:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_hit,
  output logic [11:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit
);

  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic bvalid_d, rvalid_d;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // ----------------------------------------------------------------
  // Handshake decode
  // ----------------------------------------------------------------
  // Address and data may arrive in either order; the write fires once both are held
  wire aw_take = s_axil_awvalid & s_axil_awready;
  wire w_take = s_axil_wvalid & s_axil_wready;
  wire ar_take = s_axil_arvalid & s_axil_arready;
  wire wr_fire = aw_have_q & w_have_q;
  assign aw_have_d = (aw_have_q | aw_take) & ~wr_fire;
  assign w_have_d = (w_have_q | w_take) & ~wr_fire;
  assign bvalid_d = wr_fire | (s_axil_bvalid & ~s_axil_bready);
  assign rvalid_d = ar_take | (s_axil_rvalid & ~s_axil_rready);
  assign wr_en = wr_fire;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;
  assign rd_addr = s_axil_araddr;

  // ----------------------------------------------------------------
  // Channel state
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      s_axil_awready <= 1'b0;
      s_axil_wready <= 1'b0;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= gper_pkg::RESP_OKAY;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      s_axil_awready <= ~aw_have_d & ~bvalid_d;
      s_axil_wready <= ~w_have_d & ~bvalid_d;
      s_axil_bvalid <= bvalid_d;
      if (wr_fire) begin
        s_axil_bresp <= wr_hit ? gper_pkg::RESP_OKAY : gper_pkg::RESP_SLVERR;
      end
      if (aw_take) begin
        awaddr_q <= s_axil_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axil_wdata;
        wstrb_q <= s_axil_wstrb;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h0000_0000;
      s_axil_rresp <= gper_pkg::RESP_OKAY;
    end else begin
      s_axil_arready <= ~rvalid_d;
      s_axil_rvalid <= rvalid_d;
      if (ar_take) begin
        s_axil_rdata <= rd_hit ? rd_data : 32'h0000_0000;
        s_axil_rresp <= rd_hit ? gper_pkg::RESP_OKAY : gper_pkg::RESP_SLVERR;
      end
    end
  end

endmodule : gper_axil_slave

`default_nettype wire

// ---- tb/gper_evt_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module gper_evt_host (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pin_o,
  input wire logic pin_oe,
  input wire logic active_high,
  output logic pin_level,
  output logic event_seen
);
  // ----------------------------------------------------------------
  // Board-level pin
  // ----------------------------------------------------------------
  // Pull-up on the board: a released pin reads high, never the last driven value
  assign pin_level = pin_oe ? pin_o : 1'b1;

  // ----------------------------------------------------------------
  // System event sampler
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      event_seen <= 1'b0;
    end else begin
      event_seen <= (pin_level == active_high);
    end
  end
endmodule : gper_evt_host

`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h00000000;
  logic [3:0] ws = 4'h0;
  logic [2:0] pend = 3'h0, rq = 3'h0;
  logic awr, wr, bv, arr, rv, pin_o, pin_oe, pin_lvl, irq, seen;
  logic [1:0] bresp, rresp;
  logic [31:0] rdat;
  logic [2:0] intx, msi, pme;
  logic pol = 1'b0;
  int failures = 0;
  int checks = 0;

  always #25 clock = ~clock;

  gper_router dut_u (.clock(clock), .rst_n(rst_n), .s_axil_awvalid(awv), .s_axil_awready(awr),
    .s_axil_awaddr(awa), .s_axil_wvalid(wv), .s_axil_wready(wr), .s_axil_wdata(wd), .s_axil_wstrb(ws),
    .s_axil_bvalid(bv), .s_axil_bready(bry), .s_axil_bresp(bresp), .s_axil_arvalid(arv),
    .s_axil_arready(arr), .s_axil_araddr(ara), .s_axil_rvalid(rv), .s_axil_rready(rry),
    .s_axil_rdata(rdat), .s_axil_rresp(rresp), .hp_event_pending(pend), .hp_intx_req(rq),
    .hp_msi_req(rq), .hp_pme_req(~rq), .hp_intx_out(intx), .hp_msi_out(msi), .hp_pme_out(pme),
    .gpio7_i(pin_lvl), .gpio7_o(pin_o), .gpio7_oe(pin_oe), .irq(irq));

  gper_evt_host host_u (.clock(clock), .rst_n(rst_n), .pin_o(pin_o), .pin_oe(pin_oe),
    .active_high(pol), .pin_level(pin_lvl), .event_seen(seen));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge clock);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    ws <= s;
    bry <= 1'b1;
    // Address and data may be taken at different edges; release each on its own
    while (!(ad && dd)) begin
      @(posedge clock);
      if (awv && awr) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (wv && wr) begin
        dd = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clock); while (bv !== 1'b1);
    chk({30'h0, bresp}, {30'h0, gper_pkg::RESP_OKAY});
    bry <= 1'b0;
  endtask : axw

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clock);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do @(posedge clock); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clock); while (rv !== 1'b1);
    chk(rdat, exp);
    chk({30'h0, rresp}, {30'h0, er});
    rry <= 1'b0;
  endtask : rdchk

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdchk(gper_pkg::OFF_CTRL, 32'h0, gper_pkg::RESP_OKAY);
    rdchk(gper_pkg::OFF_STATUS, 32'h0, gper_pkg::RESP_OKAY);
    rdchk(12'h4f0, 32'h0, gper_pkg::RESP_SLVERR);
    chk(pin_oe, 1'b0);
    chk(irq, 1'b0);
  endtask : t_reset

  task automatic t_pol();
    axw(gper_pkg::OFF_GPIO_CFG, 32'h1, 4'hf);
    for (int i = 0; i < 2; i++) begin
      pol <= i[0];
      axw(gper_pkg::OFF_CTRL, {31'h0, i[0]}, 4'hf);
      cyc(3);
      chk(pin_o, !pol);
      chk(pin_oe, 1'b1);
      chk(seen, 1'b0);
    end
  endtask : t_pol

  task automatic t_ports();
    logic [2:0] en;
    for (int pp = 0; pp < 2; pp++) begin
      for (int p = 0; p < 3; p++) begin
        pol <= pp[0];
        en = 3'b001 << p;
        axw(gper_pkg::OFF_CTRL, {28'h0, en, pp[0]}, 4'hf);
        pend <= 3'b111;
        rq <= 3'b101;
        cyc(3);
        rdchk(gper_pkg::OFF_STATUS, {28'h0, en, 1'b0}, gper_pkg::RESP_OKAY);
        chk(pin_o, pol);
        chk(seen, 1'b1);
        chk(intx, 3'b101 & ~en);
        chk(msi, 3'b101 & ~en);
        chk(pme, 3'b010 & ~en);
        pend <= 3'b000;
        cyc(3);
        chk(pin_o, !pol);
        rdchk(gper_pkg::OFF_STATUS, 32'h0, gper_pkg::RESP_OKAY);
      end
    end
  endtask : t_ports

  task automatic t_dis();
    pol <= 1'b1;
    axw(gper_pkg::OFF_CTRL, 32'h1, 4'hf);
    pend <= 3'b111;
    rq <= 3'b111;
    cyc(3);
    rdchk(gper_pkg::OFF_STATUS, 32'h0, gper_pkg::RESP_OKAY);
    chk(pin_o, 1'b0);
    chk(intx, 3'b111);
    axw(gper_pkg::OFF_STATUS, 32'he, 4'hf);
    rdchk(gper_pkg::OFF_STATUS, 32'h0, gper_pkg::RESP_OKAY);
    // Low byte lane off: the enables must not land
    axw(gper_pkg::OFF_CTRL, 32'hf, 4'he);
    cyc(3);
    rdchk(gper_pkg::OFF_CTRL, 32'h1, gper_pkg::RESP_OKAY);
    rdchk(gper_pkg::OFF_STATUS, 32'h0, gper_pkg::RESP_OKAY);
    pend <= 3'b000;
  endtask : t_dis

  task automatic t_alt();
    pol <= 1'b1;
    axw(gper_pkg::OFF_CTRL, 32'hf, 4'hf);
    pend <= 3'b111;
    axw(gper_pkg::OFF_GPIO_CFG, 32'h4, 4'hf);
    cyc(3);
    chk(pin_o, 1'b0);
    chk(pin_oe, 1'b1);
    axw(gper_pkg::OFF_GPIO_CFG, 32'h0, 4'hf);
    cyc(3);
    chk(pin_oe, 1'b0);
    rdchk(gper_pkg::OFF_GPIO_CFG, 32'h8, gper_pkg::RESP_OKAY);
    axw(gper_pkg::OFF_GPIO_CFG, 32'h1, 4'hf);
    cyc(3);
    chk(pin_o, 1'b1);
    rdchk(gper_pkg::OFF_STATUS, 32'he, gper_pkg::RESP_OKAY);
    pend <= 3'b000;
    axw(gper_pkg::OFF_CTRL, 32'h0, 4'hf);
  endtask : t_alt

  task automatic t_irq();
    axw(gper_pkg::OFF_INT_STATUS, 32'he, 4'hf);
    axw(gper_pkg::OFF_INT_MASK, 32'h2, 4'hf);
    pol <= 1'b1;
    axw(gper_pkg::OFF_CTRL, 32'h3, 4'hf);
    pend <= 3'b001;
    cyc(3);
    chk(irq, 1'b1);
    rdchk(gper_pkg::OFF_INT_STATUS, 32'h2, gper_pkg::RESP_OKAY);
    pend <= 3'b000;
    cyc(3);
    chk(irq, 1'b1);
    axw(gper_pkg::OFF_INT_STATUS, 32'h2, 4'hf);
    cyc(2);
    chk(irq, 1'b0);
    axw(gper_pkg::OFF_INT_MASK, 32'h0, 4'hf);
    pend <= 3'b001;
    cyc(3);
    chk(irq, 1'b0);
    rdchk(gper_pkg::OFF_INT_STATUS, 32'h2, gper_pkg::RESP_OKAY);
    pend <= 3'b000;
    axw(gper_pkg::OFF_INT_STATUS, 32'h2, 4'hf);
    rdchk(gper_pkg::OFF_INT_STATUS, 32'h0, gper_pkg::RESP_OKAY);
  endtask : t_irq

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_pol();
    t_ports();
    t_dis();
    t_alt();
    t_irq();
    give_verdict();
  end

  // Whole run needs a few hundred cycles; this leaves wide margin
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
